/* File: shared/hsc_consts.svh */
// Offsets, field positions, reset values and counts of the hold-over word
`ifndef HSC_CONSTS_SVH
`define HSC_CONSTS_SVH

`define HSC_ADDR_W 5
`define HSC_WORD_W 28
`define HSC_REG_OFFSET 5'h09
`define HSC_REG_RESET 28'h0000000
`define HSC_REG_WMASK 28'hf3fffff

`define HSC_B_KEEP1 0
`define HSC_B_KEEP2 1
`define HSC_B_CP_TRI 2
`define HSC_B_LOCK_TRIG 3
`define HSC_B_REACT_LO 4
`define HSC_B_REACT_HI 5
`define HSC_B_LOCKW2 6
`define HSC_B_LOCKW3 7
`define HSC_B_REQ_POL 8
`define HSC_B_NM_BYP 9
`define HSC_B_START_BYP 10
`define HSC_B_CLK_INDEP 11
`define HSC_B_LOCK_SKIP 12
`define HSC_B_PDF_GATE 13
`define HSC_B_MPRESET 14
`define HSC_B_FB_BIAS_LO 15
`define HSC_B_FB_BIAS_HI 16
`define HSC_B_OUT_BIAS_LO 17
`define HSC_B_OUT_BIAS_HI 18
`define HSC_B_AUX_BIAS 19
`define HSC_B_AUX_OFF 20
`define HSC_B_HISWING 21
`define HSC_B_LOW_X 24
`define HSC_B_LOW_Y 25
`define HSC_B_HIGH_X 26
`define HSC_B_HIGH_Y 27

`define HSC_REACT_W 10
`define HSC_REACT_64 10'h040
`define HSC_REACT_128 10'h080
`define HSC_REACT_256 10'h100
`define HSC_REACT_512 10'h200

`define HSC_SIG_LVCMOS 2'h0
`define HSC_SIG_LVPECL 2'h1
`define HSC_SIG_OFF 2'h2
`define HSC_SIG_LVDS 2'h3

`endif

/* File: shared/hsc_pkg.sv */
// Types shared by the hold-over configuration block
package hsc_pkg;

    typedef enum logic [1:0]
    {
        HSC_ARMED,
        HSC_ACTIVE,
        HSC_RELEASED,
        HSC_WAIT
    } hsc_keep_state_t;

endpackage

/* File: rtl/hsc_pin_sync.sv */
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none

module hsc_pin_sync #(
    parameter int WIDTH = 7
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_reg;

    // First stage is read only by the second stage
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_reg <= '0;
            sync_o <= '0;
        end
        else if (ce_i)
        begin
            meta_reg <= pin_i;
            sync_o <= meta_reg;
        end
    end

endmodule

`default_nettype wire

/* File: rtl/hsc_cfg_reg.sv */
// Hold-over, start-sync and output 9 configuration word with its effects
//
// How it works
// - Bit 0 enables first hold-over function
// - Bit 1 enables second hold-over function
// - Bit 2 three-states charge pump like pin
// - Bit 3: hold follows analog lock signal
// - Bits 5:4 pick 64/128/256/512 reactivation cycles
// - Bits 7:6 are upper lock-window bits
// - Bit 8 low inverts internal freeze/reset requests
// - Bit 9 bypasses N/M sync in gating mode
// - Bit 10 bypasses oscillator start synchronisation
// - Bit 11 ignores oscillator/auxiliary clock presence
// - Bit 12 skips waiting for first lock
// - Bit 13 gates start on phase-detector frequency
// - Bit 14 stops first-freeze presetting M divider
// - Bits 16:15 feedback divider bias reduction
// - Bits 18:17 output divider bias reduction
// - Bit 19 biases auxiliary negative pin internally
// - Bit 20 disables auxiliary input buffer
// - Bit 21 high swing for output 9
// - Bits 25:24 output 9 mode, pin low
// - Bits 27:26 output 9 mode, pin high
`timescale 1ns/1ps
`default_nettype none
`include "hsc_consts.svh"

module hsc_cfg_reg
    import hsc_pkg::*;
#(
    parameter int ADDR_W = `HSC_ADDR_W,
    parameter int WORD_W = `HSC_WORD_W
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Serial control port, decoded word access
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic [ADDR_W-1:0] cfg_addr_i,
    input wire logic [WORD_W-1:0] cfg_wdata_i,
    output logic [WORD_W-1:0] cfg_rdata_o,
    output logic cfg_hit_o,
    // Power-up load from nonvolatile storage
    input wire logic nvm_load_i,
    input wire logic [WORD_W-1:0] nvm_data_i,
    // Pins and analog status, asynchronous to clk_sys_i
    input wire logic freeze_pin_i,
    input wire logic pll_lock_i,
    input wire logic profile_select_pin_b_i,
    input wire logic divider_gating_mode_i,
    input wire logic ref_clk_i,
    input wire logic osc_clk_i,
    input wire logic clocks_present_i,
    input wire logic pd_freq_above_i,
    // Same-domain requests and selections
    input wire logic sw_freeze_req_i,
    input wire logic sw_reset_req_i,
    input wire logic start_i,
    input wire logic feedback_path_select_i,
    input wire logic output_path_select_i,
    // Effects of the word
    output logic freq_keep_func1_active_o,
    output logic freq_keep_func2_active_o,
    output logic first_freeze_n_o,
    output logic cp_tristate_o,
    output logic [1:0] lock_window_hi_o,
    output logic sw_freeze_int_o,
    output logic sw_reset_int_o,
    output logic nm_start_sync_en_o,
    output logic nm_start_sync_bypass_o,
    output logic start_o,
    output logic sync_logic_run_o,
    output logic m_div_preset_n_o,
    output logic [1:0] feedback_divider_bias_o,
    output logic [1:0] output_divider_bias_o,
    output logic aux_neg_internal_bias_o,
    output logic aux_input_buffer_en_o,
    output logic out9_high_swing_o,
    output logic [1:0] out9_sig_mode_o
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    localparam int NPIN = 8;

    logic [NPIN-1:0] pins_sync;
    logic freeze_pin_s;
    logic lock_s;
    logic pin_b_s;
    logic gating_s;
    logic ref_clk_s;
    logic osc_clk_s;
    logic clk_present_s;
    logic pd_above_s;

    hsc_pin_sync #(
        .WIDTH(NPIN)
    ) u_pin_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .pin_i({pd_above_s_unused_guard(pd_freq_above_i), clocks_present_i,
            osc_clk_i, ref_clk_i, divider_gating_mode_i,
            profile_select_pin_b_i, pll_lock_i, freeze_pin_i}),
        .sync_o(pins_sync)
    );

    // Identity helper keeps the concatenation readable
    function automatic logic pd_above_s_unused_guard(input logic v);
        return v;
    endfunction

    assign freeze_pin_s = pins_sync[0];
    assign lock_s = pins_sync[1];
    assign pin_b_s = pins_sync[2];
    assign gating_s = pins_sync[3];
    assign ref_clk_s = pins_sync[4];
    assign osc_clk_s = pins_sync[5];
    assign clk_present_s = pins_sync[6];
    assign pd_above_s = pins_sync[7];

    // Edge detectors look only at synchronised levels
    logic ref_clk_d_reg;
    logic osc_clk_d_reg;
    logic lock_d_reg;
    logic ref_edge;
    logic osc_edge;
    logic lock_rise;

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ref_clk_d_reg <= 1'b0;
            osc_clk_d_reg <= 1'b0;
            lock_d_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            ref_clk_d_reg <= ref_clk_s;
            osc_clk_d_reg <= osc_clk_s;
            lock_d_reg <= lock_s;
        end
    end

    assign ref_edge = ref_clk_s & ~ref_clk_d_reg;
    assign osc_edge = osc_clk_s & ~osc_clk_d_reg;
    assign lock_rise = lock_s & ~lock_d_reg;

    ////////////////////////////////////////////////////////////////////////
    // Configuration word

    logic [WORD_W-1:0] cfg_reg;
    logic [WORD_W-1:0] cfg_next;
    logic addr_hit;

    assign addr_hit = (cfg_addr_i == ADDR_W'(`HSC_REG_OFFSET));

    // A software write in the same cycle as the load wins; the load only
    // happens at power-up, so the later intent is the software one
    always_comb
    begin
        cfg_next = cfg_reg;
        if (nvm_load_i)
        begin
            cfg_next = nvm_data_i;
        end
        if (cfg_wr_i && addr_hit)
        begin
            cfg_next = cfg_wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cfg_reg <= WORD_W'(`HSC_REG_RESET);
        end
        else if (ce_i)
        begin
            cfg_reg <= cfg_next;
        end
    end

    // Reserved bits 23:22 are stored but read back as zero
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cfg_rdata_o <= '0;
            cfg_hit_o <= 1'b0;
        end
        else if (ce_i)
        begin
            cfg_hit_o <= cfg_rd_i & addr_hit;
            if (cfg_rd_i && addr_hit)
            begin
                cfg_rdata_o <= cfg_reg & WORD_W'(`HSC_REG_WMASK);
            end
            else if (cfg_rd_i)
            begin
                cfg_rdata_o <= '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Hold-over request and reactivation

    function automatic logic [`HSC_REACT_W-1:0] react_cycles(
        input logic [1:0] code
    );
        logic [`HSC_REACT_W-1:0] n;
        n = `HSC_REACT_64;
        unique case (code)
            2'h0: n = `HSC_REACT_64;
            2'h1: n = `HSC_REACT_128;
            2'h2: n = `HSC_REACT_256;
            2'h3: n = `HSC_REACT_512;
        endcase
        return n;
    endfunction

    logic hold_req;
    logic [1:0] react_code;

    // Lock-triggered mode follows the analog lock; otherwise the pin
    assign hold_req = cfg_reg[`HSC_B_LOCK_TRIG] ? lock_s
                                                : freeze_pin_s;
    // Code is read as (bit4, bit5)
    assign react_code = {cfg_reg[`HSC_B_REACT_LO], cfg_reg[`HSC_B_REACT_HI]};

    hsc_keep_state_t keep_reg;
    logic [`HSC_REACT_W-1:0] react_cnt_reg;

    // First activation is immediate; later ones wait the chosen count
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            keep_reg <= HSC_ARMED;
        end
        else if (ce_i)
        begin
            if (!cfg_reg[`HSC_B_KEEP1])
            begin
                keep_reg <= HSC_ARMED;
            end
            else
            begin
                unique case (keep_reg)
                    HSC_ARMED:
                    begin
                        if (hold_req)
                        begin
                            keep_reg <= HSC_ACTIVE;
                        end
                    end
                    HSC_ACTIVE:
                    begin
                        if (!hold_req)
                        begin
                            keep_reg <= HSC_RELEASED;
                        end
                    end
                    HSC_RELEASED:
                    begin
                        if (hold_req)
                        begin
                            keep_reg <= HSC_WAIT;
                        end
                    end
                    HSC_WAIT:
                    begin
                        if (!hold_req)
                        begin
                            keep_reg <= HSC_RELEASED;
                        end
                        else if (ref_edge && react_cnt_reg ==
                                 react_cycles(react_code) - 1'b1)
                        begin
                            keep_reg <= HSC_ACTIVE;
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            react_cnt_reg <= '0;
        end
        else if (ce_i)
        begin
            if (keep_reg != HSC_WAIT)
            begin
                react_cnt_reg <= '0;
            end
            else if (ref_edge)
            begin
                react_cnt_reg <= react_cnt_reg + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Start synchronisation gating

    logic first_lock_seen_reg;
    logic start_osc_reg;
    logic sync_run;

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            first_lock_seen_reg <= 1'b0;
        end
        else if (ce_i && lock_rise)
        begin
            first_lock_seen_reg <= 1'b1;
        end
    end

    assign sync_run = (cfg_reg[`HSC_B_CLK_INDEP] | clk_present_s)
        & (cfg_reg[`HSC_B_LOCK_SKIP] | first_lock_seen_reg)
        & (~cfg_reg[`HSC_B_PDF_GATE] | pd_above_s);

    // Start is re-timed on oscillator edges; cost is up to one osc period
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            start_osc_reg <= 1'b0;
        end
        else if (ce_i && osc_edge)
        begin
            start_osc_reg <= start_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered effects

    logic keep1_active;
    logic [1:0] sig_mode;

    assign keep1_active = (keep_reg == HSC_ACTIVE);
    assign sig_mode = pin_b_s
        ? {cfg_reg[`HSC_B_HIGH_X], cfg_reg[`HSC_B_HIGH_Y]}
        : {cfg_reg[`HSC_B_LOW_X], cfg_reg[`HSC_B_LOW_Y]};

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            freq_keep_func1_active_o <= 1'b0;
            freq_keep_func2_active_o <= 1'b0;
            first_freeze_n_o <= 1'b1;
            m_div_preset_n_o <= 1'b1;
            cp_tristate_o <= 1'b0;
        end
        else if (ce_i)
        begin
            freq_keep_func1_active_o <= keep1_active;
            freq_keep_func2_active_o <= cfg_reg[`HSC_B_KEEP2]
                                        & hold_req;
            first_freeze_n_o <= ~keep1_active;
            m_div_preset_n_o <= cfg_reg[`HSC_B_MPRESET]
                                | ~keep1_active;
            cp_tristate_o <= cfg_reg[`HSC_B_CP_TRI]
                             | freeze_pin_s;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sw_freeze_int_o <= 1'b0;
            sw_reset_int_o <= 1'b0;
            nm_start_sync_en_o <= 1'b0;
            nm_start_sync_bypass_o <= 1'b0;
            start_o <= 1'b0;
            sync_logic_run_o <= 1'b0;
        end
        else if (ce_i)
        begin
            sw_freeze_int_o <= sw_freeze_req_i
                               ^ ~cfg_reg[`HSC_B_REQ_POL];
            sw_reset_int_o <= sw_reset_req_i
                              ^ ~cfg_reg[`HSC_B_REQ_POL];
            nm_start_sync_en_o <= gating_s
                                  & ~cfg_reg[`HSC_B_NM_BYP];
            nm_start_sync_bypass_o <= gating_s
                                      & cfg_reg[`HSC_B_NM_BYP];
            sync_logic_run_o <= sync_run;
            start_o <= cfg_reg[`HSC_B_START_BYP] ? start_i
                       : (sync_run & start_osc_reg);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            lock_window_hi_o <= 2'h0;
            feedback_divider_bias_o <= 2'h0;
            output_divider_bias_o <= 2'h0;
            aux_neg_internal_bias_o <= 1'b0;
            aux_input_buffer_en_o <= 1'b0;
            out9_high_swing_o <= 1'b0;
            out9_sig_mode_o <= `HSC_SIG_LVCMOS;
        end
        else if (ce_i)
        begin
            lock_window_hi_o <= {cfg_reg[`HSC_B_LOCKW3],
                                 cfg_reg[`HSC_B_LOCKW2]};
            feedback_divider_bias_o <= {cfg_reg[`HSC_B_FB_BIAS_HI],
                                        cfg_reg[`HSC_B_FB_BIAS_LO]};
            output_divider_bias_o <= {cfg_reg[`HSC_B_OUT_BIAS_HI],
                                      cfg_reg[`HSC_B_OUT_BIAS_LO]};
            aux_neg_internal_bias_o <= cfg_reg[`HSC_B_AUX_BIAS];
            aux_input_buffer_en_o <= ~cfg_reg[`HSC_B_AUX_OFF]
                & (feedback_path_select_i
                   | output_path_select_i);
            // Swing only matters for the differential levels
            out9_high_swing_o <= cfg_reg[`HSC_B_HISWING]
                & (sig_mode == `HSC_SIG_LVPECL
                   || sig_mode == `HSC_SIG_LVDS);
            out9_sig_mode_o <= sig_mode;
        end
    end

endmodule

`default_nettype wire

/* File: test/hsc_cfg_reg_props.sv */
// Port-level assertions for the hold-over configuration word
`timescale 1ns/1ps
`default_nettype none
`include "hsc_consts.svh"

module hsc_cfg_reg_chk #(
    parameter int ADDR_W = 5,
    parameter int WORD_W = 28
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic [ADDR_W-1:0] cfg_addr_i,
    input wire logic [WORD_W-1:0] cfg_wdata_i,
    input wire logic [WORD_W-1:0] cfg_rdata_o,
    input wire logic cfg_hit_o,
    input wire logic nvm_load_i,
    input wire logic freq_keep_func1_active_o,
    input wire logic first_freeze_n_o,
    input wire logic m_div_preset_n_o,
    input wire logic cp_tristate_o,
    input wire logic [1:0] lock_window_hi_o,
    input wire logic [1:0] feedback_divider_bias_o,
    input wire logic [1:0] output_divider_bias_o,
    input wire logic aux_neg_internal_bias_o,
    input wire logic out9_high_swing_o,
    input wire logic [1:0] out9_sig_mode_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    logic rd_hit;
    logic wr_hit;
    logic quiet;
    assign rd_hit = ce_i && cfg_rd_i && cfg_addr_i == `HSC_REG_OFFSET;
    assign wr_hit = ce_i && cfg_wr_i && cfg_addr_i == `HSC_REG_OFFSET;
    // A load or a second write would change the word under the check
    assign quiet = ce_i && !cfg_wr_i && !nvm_load_i;
    a_hit_after_read: assert property (rd_hit |=> cfg_hit_o)
        else $error("no hit after a mapped read");
    a_unmapped_read_zero: assert property (
        ce_i && cfg_rd_i && cfg_addr_i != `HSC_REG_OFFSET
        |=> !cfg_hit_o && cfg_rdata_o == '0)
        else $error("unmapped read not refused");
    a_reserved_read_zero: assert property (
        cfg_hit_o |-> cfg_rdata_o[23:22] == 2'h0)
        else $error("reserved bits read nonzero");
    a_write_read_back: assert property (
        wr_hit ##1 quiet [*3] ##1 (rd_hit && !nvm_load_i)
        |=> cfg_rdata_o == ($past(cfg_wdata_i, 5) & `HSC_REG_WMASK))
        else $error("read back differs from write");
    a_field_map: assert property (
        wr_hit ##1 quiet |=> {aux_neg_internal_bias_o, output_divider_bias_o,
        feedback_divider_bias_o, lock_window_hi_o} ==
        {$past(cfg_wdata_i[19:15], 2), $past(cfg_wdata_i[7:6], 2)})
        else $error("field outputs differ from written word");
    a_cp_tristate_set: assert property (
        wr_hit && cfg_wdata_i[2] ##1 quiet |=> cp_tristate_o)
        else $error("charge pump not three-stated");
    a_freeze_pair: assert property (
        first_freeze_n_o == !freq_keep_func1_active_o)
        else $error("freeze level disagrees with hold state");
    a_preset_follows: assert property (
        first_freeze_n_o |-> m_div_preset_n_o)
        else $error("divider preset without freeze");
    a_swing_mode: assert property (
        out9_high_swing_o |-> out9_sig_mode_o[0])
        else $error("high swing outside differential modes");
endmodule

bind hsc_cfg_reg hsc_cfg_reg_chk #(.ADDR_W(ADDR_W), .WORD_W(WORD_W)) chk_u (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i),
    .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
    .cfg_hit_o(cfg_hit_o), .nvm_load_i(nvm_load_i),
    .freq_keep_func1_active_o(freq_keep_func1_active_o),
    .first_freeze_n_o(first_freeze_n_o), .m_div_preset_n_o(m_div_preset_n_o),
    .cp_tristate_o(cp_tristate_o), .lock_window_hi_o(lock_window_hi_o),
    .feedback_divider_bias_o(feedback_divider_bias_o),
    .output_divider_bias_o(output_divider_bias_o),
    .aux_neg_internal_bias_o(aux_neg_internal_bias_o),
    .out9_high_swing_o(out9_high_swing_o), .out9_sig_mode_o(out9_sig_mode_o));
`default_nettype wire

/* File: test/test_holdover_sync_config_register.sv */
// Self-checking bench for the hold-over configuration word
`timescale 1ns/1ps
`default_nettype none
`include "hsc_consts.svh"

module test_holdover_sync_config_register;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, nvm_ld = 1'b0;
    logic frz = 1'b0, lock = 1'b0, pinb = 1'b0, gate = 1'b0, refc = 1'b0;
    logic pres = 1'b0, pdf = 1'b0, hit, osc = 1'b0, fbs = 1'b1;
    logic [4:0] addr = 5'h00;
    logic [27:0] wdata = 28'h0, nvm_d = 28'h0, rdata, rdw;
    logic hit_o, k1, k2, ffn, cpt, sfi, sri, nme, nmb, st, run, mpn, axb;
    logic axe, hsw;
    logic [1:0] lw, fbb, odb, mode;
    int miscompares = 0;
    int comparisons = 0;

    // Reset request and output mux select held low
    hsc_cfg_reg dut_u (.clk_sys_i(clk), .rst_n_i(rst_n), .ce_i(1'b1),
        .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_addr_i(addr), .cfg_wdata_i(wdata),
        .cfg_rdata_o(rdata), .cfg_hit_o(hit_o), .nvm_load_i(nvm_ld),
        .nvm_data_i(nvm_d), .freeze_pin_i(frz), .pll_lock_i(lock),
        .profile_select_pin_b_i(pinb), .divider_gating_mode_i(gate),
        .ref_clk_i(refc), .osc_clk_i(osc), .clocks_present_i(pres),
        .pd_freq_above_i(pdf), .sw_freeze_req_i(1'b1), .sw_reset_req_i(1'b0),
        .start_i(1'b1), .feedback_path_select_i(fbs),
        .output_path_select_i(1'b0), .freq_keep_func1_active_o(k1),
        .freq_keep_func2_active_o(k2), .first_freeze_n_o(ffn),
        .cp_tristate_o(cpt), .lock_window_hi_o(lw), .sw_freeze_int_o(sfi),
        .sw_reset_int_o(sri), .nm_start_sync_en_o(nme),
        .nm_start_sync_bypass_o(nmb), .start_o(st), .sync_logic_run_o(run),
        .m_div_preset_n_o(mpn), .feedback_divider_bias_o(fbb),
        .output_divider_bias_o(odb), .aux_neg_internal_bias_o(axb),
        .aux_input_buffer_en_o(axe), .out9_high_swing_o(hsw),
        .out9_sig_mode_o(mode));

    always #12.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [28:0] got, input logic [28:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Ends mid-cycle so samples never race the edge
    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic wr_w(input logic [4:0] a, input logic [27:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        waitc(2);
    endtask

    task automatic rd_w(input logic [4:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        rdw = rdata;
        hit = hit_o;
    endtask

    task automatic toggle(input int n);
        repeat (n)
        begin
            repeat (4) @(posedge clk);
            refc <= ~refc;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        waitc(1);
        chk({ffn, mpn, k1}, 3'b110);
        rd_w(`HSC_REG_OFFSET);
        chk({hit, rdw}, {1'b1, `HSC_REG_RESET});
    endtask

    task automatic t_regs();
        logic [27:0] p;
        for (int i = 0; i < 2; i++)
        begin
            p = i[0] ? 28'h5a6c3b5 : 28'ha593c4a;
            wr_w(`HSC_REG_OFFSET, p);
            rd_w(`HSC_REG_OFFSET);
            chk(rdw, p & `HSC_REG_WMASK);
            chk({axb, odb, fbb, lw}, {p[19:15], p[7:6]});
            wr_w(5'h0a, ~p);
            rd_w(5'h0a);
            chk({hit, rdw}, 29'h0);
            rd_w(`HSC_REG_OFFSET);
            chk(rdw, p & `HSC_REG_WMASK);
        end
        @(posedge clk);
        nvm_d <= 28'h3c0ff0f;
        nvm_ld <= 1'b1;
        @(posedge clk);
        nvm_ld <= 1'b0;
        rd_w(`HSC_REG_OFFSET);
        chk(rdw, 28'h3c0ff0f & `HSC_REG_WMASK);
    endtask

    task automatic t_misc();
        logic b;
        @(posedge clk);
        gate <= 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            b = i[0];
            wr_w(`HSC_REG_OFFSET, b ? 28'h100304 : 28'h0);
            chk({cpt, sfi, sri}, {b, b, !b});
            chk({nme, nmb, axe}, {!b, b, !b});
        end
        wr_w(`HSC_REG_OFFSET, 28'h0);
        @(posedge clk);
        frz <= 1'b1;
        waitc(4);
        chk(cpt, 1'b1);
        @(posedge clk);
        fbs <= 1'b0;
        waitc(2);
        chk(axe, 1'b0);
        @(posedge clk);
        fbs <= 1'b1;
    endtask

    task automatic t_out9();
        logic [1:0] c;
        for (int k = 0; k < 8; k++)
        begin
            c = k[1:0];
            @(posedge clk);
            pinb <= k[2];
            wr_w(`HSC_REG_OFFSET, k[2] ? {c[0], c[1], ~c[0], ~c[1], 24'h200000}
                : {~c[0], ~c[1], c[0], c[1], 24'h200000});
            waitc(2);
            chk({mode, hsw}, {c, c[0]});
        end
    endtask

    task automatic t_sync();
        // Each row: bits 13..10 of the word, frequency pin, expected run
        logic [5:0] row [6] = '{6'b011101, 6'b010100, 6'b111100,
            6'b111111, 6'b001100, 6'b011001};
        foreach (row[j])
        begin
            @(posedge clk);
            pdf <= row[j][1];
            wr_w(`HSC_REG_OFFSET, {14'h0, row[j][5:2], 10'h0});
            chk(run, row[j][0]);
            chk(st, row[j][2]);
        end
        // Last row leaves sync running with the start re-timed on osc edges
        @(posedge clk);
        osc <= 1'b1;
        waitc(5);
        chk(st, 1'b1);
        @(posedge clk);
        osc <= 1'b0;
    endtask

    task automatic t_hold();
        logic [1:0] c;
        for (int k = 0; k < 4; k++)
        begin
            c = k[1:0];
            @(posedge clk);
            frz <= 1'b0;
            wr_w(`HSC_REG_OFFSET, 28'h0);
            wr_w(`HSC_REG_OFFSET, {13'h0, (c == 2'h3), 8'h0, c[0], c[1], 4'h3});
            @(posedge clk);
            frz <= 1'b1;
            waitc(5);
            chk({k1, k2, ffn, mpn}, {3'b110, (c == 2'h3)});
            @(posedge clk);
            frz <= 1'b0;
            waitc(5);
            chk({k1, k2, mpn}, 3'b001);
            @(posedge clk);
            frz <= 1'b1;
            waitc(6);
            toggle(2 * (64 << k) - 2);
            waitc(8);
            chk(k1, 1'b0);
            toggle(2);
            waitc(8);
            chk(k1, 1'b1);
        end
        wr_w(`HSC_REG_OFFSET, 28'h0);
        wr_w(`HSC_REG_OFFSET, 28'h9);
        @(posedge clk);
        lock <= 1'b1;
        waitc(5);
        chk(k1, 1'b1);
        @(posedge clk);
        lock <= 1'b0;
        waitc(5);
        chk(k1, 1'b0);
    endtask

    task automatic final_report();
        $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_regs();
        t_misc();
        t_out9();
        t_sync();
        t_hold();
        final_report();
    end

    // The hold-over counts need about 8000 cycles in all
    initial
    begin
        repeat (30000) @(posedge clk);
        miscompares++;
        final_report();
    end
endmodule
`default_nettype wire
